// ### src/dummy_ctrl_pkg.sv
// Constants and types for the host controller that programs variable dummy cycles.
// ****************************************************************************
// Summary of operation
// - Bits 30-29 give field width two to five.
// - Bit 28 picks plain or addressed commands.
// - Byte-zero option puts local address last.
// - Byte-one option never with 8-bit addressing.
// - Align written field to given LSb position.
// - Addressed access takes local address from 23-16.
// - Bits 23-20 flag modes using shared dummy.
// - Bits 19-16 give dummy count for flagged modes.
// - Single-line mode always uses zero dummy cycles.
// - Unflagged mode may work with another count.
// - Read opcode zero means no read command.
// - Write opcode zero means no write command.
// - Erase word write opcode zero means read-only.
// - Erase word 23-16 is address or modes.
// - Erase word bit 29 marks shared error bit.
// ****************************************************************************
package dummy_ctrl_pkg;

	// ************************************************************************
	// Register map of the software port
	// ************************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SET_WORD = 8'h04;
	localparam logic [7:0] OFF_ERASE_WORD = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_DECODE = 8'h10;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	// Control register fields.
	localparam int GO_SET_BIT = 0;
	localparam int GO_ERASE_BIT = 1;
	localparam int VAL_LO = 8;
	localparam int VAL_HI = 12;
	localparam int MODE_LO = 16;
	localparam int MODE_HI = 18;
	localparam int ALEN_LO = 20;
	localparam int ALEN_HI = 21;
	localparam int OVR_LO = 24;
	localparam int OVR_HI = 27;

	// Status register fields.
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_ERR_LO = 2;
	localparam int ST_ERR_HI = 4;
	localparam int ST_UNLISTED_BIT = 5;
	localparam int ST_ERASE_BIT = 6;
	localparam int ST_ERASE_RO_BIT = 7;
	localparam int ST_SHARED_BIT = 8;
	localparam int ST_RDATA_LO = 16;
	localparam int ST_RDATA_HI = 23;

	// ************************************************************************
	// Layout of a parameter word
	// ************************************************************************
	localparam int PW_SUPPORT = 31;
	localparam int PW_WIDTH_HI = 30;
	localparam int PW_WIDTH_LO = 29;
	localparam int PW_SHARED = 29;
	localparam int PW_BY_ADDR = 28;
	localparam int PW_BYTE1 = 27;
	localparam int PW_LSB_HI = 26;
	localparam int PW_LSB_LO = 24;
	localparam int PW_ADDR_HI = 23;
	localparam int PW_ADDR_LO = 16;
	localparam int PW_FLAG_HI = 23;
	localparam int PW_FLAG_LO = 20;
	localparam int PW_DC_HI = 19;
	localparam int PW_DC_LO = 16;
	localparam int PW_RD_HI = 15;
	localparam int PW_RD_LO = 8;
	localparam int PW_WR_HI = 7;
	localparam int PW_WR_LO = 0;
	localparam logic [7:0] NO_OPCODE = 8'h00;
	localparam logic [3:0] MIN_FIELD_BITS = 4'h2;
	localparam logic [3:0] REG_BITS = 4'h8;

	// ************************************************************************
	// Types
	// ************************************************************************
	typedef enum logic [2:0] {
		MODE_1S1S1S, MODE_4S4S4S, MODE_4S4D4D, MODE_8S8S8S, MODE_8D8D8D
	} bus_mode_type;

	typedef enum logic [1:0] {ALEN_8, ALEN_24, ALEN_32} addr_len_type;

	typedef enum logic [2:0] {
		ERR_NONE, ERR_UNSUP, ERR_NO_WRITE, ERR_NO_READ, ERR_WIDTH, ERR_FIELD, ERR_ADDR,
		ERR_MODE
	} err_type;

	typedef enum logic [2:0] {
		ST_IDLE, ST_RD_ISSUE, ST_RD_WAIT, ST_WR_ISSUE, ST_WR_WAIT
	} state_type;

	typedef struct packed {
		logic supported;
		logic [1:0] width_code;
		logic by_addr;
		logic byte1;
		logic [2:0] lsb_pos;
		logic [7:0] local_addr;
		logic [3:0] mode_flags;
		logic [3:0] dummy;
		logic [7:0] rd_op;
		logic [7:0] wr_op;
		logic shared;
	} param_fields_type;

	typedef struct packed {
		logic valid;
		logic is_write;
		logic [7:0] opcode;
		logic has_addr;
		addr_len_type addr_len;
		logic [31:0] addr;
		bus_mode_type mode;
		logic [3:0] dummy;
		logic [7:0] wdata;
	} serial_cmd_type;

endpackage : dummy_ctrl_pkg

// ### src/param_word_decode.sv
// Field decoder for one received parameter word.
`timescale 1ns/1ps
module param_word_decode (
	// Parameter word as captured.
	input wire logic [31:0] word_i,
	// Decoded fields.
	output dummy_ctrl_pkg::param_fields_type fields_o
);

	// All fields come out in the cycle the word is held; an unsupported word reads as zero.
	always_comb begin
		fields_o = '0;
		if (word_i[dummy_ctrl_pkg::PW_SUPPORT]) begin
			fields_o.supported = 1'b1;
			fields_o.width_code = word_i[dummy_ctrl_pkg::PW_WIDTH_HI:dummy_ctrl_pkg::PW_WIDTH_LO];
			fields_o.by_addr = word_i[dummy_ctrl_pkg::PW_BY_ADDR];
			fields_o.byte1 = word_i[dummy_ctrl_pkg::PW_BYTE1];
			fields_o.lsb_pos = word_i[dummy_ctrl_pkg::PW_LSB_HI:dummy_ctrl_pkg::PW_LSB_LO];
			fields_o.rd_op = word_i[dummy_ctrl_pkg::PW_RD_HI:dummy_ctrl_pkg::PW_RD_LO];
			fields_o.wr_op = word_i[dummy_ctrl_pkg::PW_WR_HI:dummy_ctrl_pkg::PW_WR_LO];
			fields_o.shared = word_i[dummy_ctrl_pkg::PW_SHARED];
			// The same byte is either a register address or a mode list, never both.
			if (word_i[dummy_ctrl_pkg::PW_BY_ADDR]) begin
				fields_o.local_addr = word_i[dummy_ctrl_pkg::PW_ADDR_HI:dummy_ctrl_pkg::PW_ADDR_LO];
			end else begin
				fields_o.mode_flags = word_i[dummy_ctrl_pkg::PW_FLAG_HI:dummy_ctrl_pkg::PW_FLAG_LO];
				fields_o.dummy = word_i[dummy_ctrl_pkg::PW_DC_HI:dummy_ctrl_pkg::PW_DC_LO];
			end
		end
	end

endmodule : param_word_decode

// ### src/wait_field_merge.sv
// Aligns a wait-state value into its register byte and checks that it fits.
`timescale 1ns/1ps
module wait_field_merge (
	// Current register content and new setting.
	input wire logic [7:0] old_i,
	input wire logic [4:0] value_i,
	// Field shape from the settings word.
	input wire logic [1:0] width_code_i,
	input wire logic [2:0] lsb_pos_i,
	// Results.
	output logic [7:0] merged_o,
	output logic [7:0] mask_o,
	output logic value_fits_o,
	output logic field_fits_o
);

	logic [3:0] width;
	logic [7:0] ones;

	// Field width is the code plus two, so the mask is at most five ones.
	always_comb begin
		width = {2'h0, width_code_i} + dummy_ctrl_pkg::MIN_FIELD_BITS;
		ones = 8'((9'h001 << width) - 9'h001);
		mask_o = ones << lsb_pos_i;
		field_fits_o = ({1'b0, lsb_pos_i} + width) <= dummy_ctrl_pkg::REG_BITS;
		value_fits_o = (value_i & ~ones[4:0]) == 5'h00;
		// Bits outside the field keep what the register held.
		merged_o = (old_i & ~mask_o) | ((8'({3'h0, value_i}) << lsb_pos_i) & mask_o);
	end

endmodule : wait_field_merge

// ### src/dummy_cycle_host.sv
// Host controller that programs variable dummy cycles and reads the erase error bit.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module dummy_cycle_host (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// Software register port.
	input wire logic [7:0] sw_addr_i,
	input wire logic [31:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [31:0] sw_rdata_o,
	// Serial command engine.
	output dummy_ctrl_pkg::serial_cmd_type cmd_o,
	input wire logic cmd_ready_i,
	input wire logic rsp_valid_i,
	input wire logic [7:0] rsp_data_i,
	// Status.
	output logic busy_o
);

	// ************************************************************************
	// Declarations
	// ************************************************************************
	logic [31:0] set_word;
	logic [31:0] erase_word;
	logic [4:0] wait_value;
	logic [2:0] mode_raw;
	dummy_ctrl_pkg::addr_len_type alen;
	logic [3:0] dummy_ovr;
	dummy_ctrl_pkg::param_fields_type set_dec;
	dummy_ctrl_pkg::param_fields_type erase_dec;
	dummy_ctrl_pkg::param_fields_type go_f;
	dummy_ctrl_pkg::param_fields_type cur_f;
	dummy_ctrl_pkg::state_type state;
	dummy_ctrl_pkg::err_type err;
	dummy_ctrl_pkg::err_type go_err;
	dummy_ctrl_pkg::bus_mode_type req_mode;
	dummy_ctrl_pkg::bus_mode_type cur_mode;
	dummy_ctrl_pkg::addr_len_type req_alen;
	logic op_erase;
	logic done;
	logic unlisted;
	logic erase_bit;
	logic [7:0] last_rdata;
	logic go_set;
	logic go_erase;
	logic go_any;
	logic [4:0] merge_value;
	logic [7:0] merge_old;
	logic [7:0] merged;
	logic [7:0] merge_mask;
	logic value_fits;
	logic field_fits;
	logic [4:0] req_value;
	logic [3:0] req_ovr;
	logic [2:0] req_mode_raw;

	// ************************************************************************
	// Helper functions
	// ************************************************************************

	// Local register address goes in the last byte, or in byte one when flagged.
	function automatic logic [31:0] place_addr(input dummy_ctrl_pkg::param_fields_type f);
		if (f.byte1) begin
			place_addr = {16'h0000, f.local_addr, 8'h00};
		end else begin
			place_addr = {24'h00_0000, f.local_addr};
		end
	endfunction : place_addr

	// Flag bit of a mode above single line; mode one maps to the lowest flag.
	function automatic logic mode_flagged(input dummy_ctrl_pkg::param_fields_type f,
			input dummy_ctrl_pkg::bus_mode_type m);
		logic [1:0] idx;
		idx = 2'(3'(m) - 3'h1);
		mode_flagged = (m != dummy_ctrl_pkg::MODE_1S1S1S) && f.mode_flags[idx];
	endfunction : mode_flagged

	// Dummy count for a read: none on one line, the shared count where flagged.
	function automatic logic [3:0] pick_dummy(input dummy_ctrl_pkg::param_fields_type f,
			input dummy_ctrl_pkg::bus_mode_type m, input logic [3:0] ovr);
		if (m == dummy_ctrl_pkg::MODE_1S1S1S) begin
			pick_dummy = 4'h0;
		end else if (!f.by_addr && mode_flagged(f, m)) begin
			pick_dummy = f.dummy;
		end else begin
			pick_dummy = ovr;
		end
	endfunction : pick_dummy

	// One command for the serial engine; plain commands carry no address.
	function automatic dummy_ctrl_pkg::serial_cmd_type make_cmd(input logic wr,
			input dummy_ctrl_pkg::param_fields_type f, input dummy_ctrl_pkg::addr_len_type al,
			input dummy_ctrl_pkg::bus_mode_type m, input logic [3:0] ovr,
			input logic [7:0] data);
		make_cmd = '0;
		make_cmd.valid = 1'b1;
		make_cmd.is_write = wr;
		make_cmd.opcode = wr ? f.wr_op : f.rd_op;
		make_cmd.has_addr = f.by_addr;
		make_cmd.addr_len = f.by_addr ? al : dummy_ctrl_pkg::ALEN_8;
		make_cmd.addr = f.by_addr ? place_addr(f) : 32'h0000_0000;
		make_cmd.mode = m;
		make_cmd.dummy = wr ? 4'h0 : pick_dummy(f, m, ovr);
		make_cmd.wdata = data;
	endfunction : make_cmd

	// ************************************************************************
	// Decoders and field merge
	// ************************************************************************
	param_word_decode set_decode (
		.word_i(set_word),
		.fields_o(set_dec)
	);

	param_word_decode erase_decode (
		.word_i(erase_word),
		.fields_o(erase_dec)
	);

	// Before the read the register is taken as zero; after it, the answer is merged.
	assign merge_value = (state == dummy_ctrl_pkg::ST_IDLE) ? req_value : wait_value;
	assign merge_old = (state == dummy_ctrl_pkg::ST_RD_WAIT) ? rsp_data_i : 8'h00;

	wait_field_merge merge (
		.old_i(merge_old),
		.value_i(merge_value),
		.width_code_i(set_dec.width_code),
		.lsb_pos_i(set_dec.lsb_pos),
		.merged_o(merged),
		.mask_o(merge_mask),
		.value_fits_o(value_fits),
		.field_fits_o(field_fits)
	);

	// ************************************************************************
	// Request decode and checks
	// ************************************************************************

	// A start only counts while idle; a set request wins over an erase read.
	assign go_any = sw_wr_i && (sw_addr_i == dummy_ctrl_pkg::OFF_CTRL)
		&& (state == dummy_ctrl_pkg::ST_IDLE)
		&& (sw_wdata_i[dummy_ctrl_pkg::GO_SET_BIT] || sw_wdata_i[dummy_ctrl_pkg::GO_ERASE_BIT]);
	assign go_set = go_any && sw_wdata_i[dummy_ctrl_pkg::GO_SET_BIT];
	assign go_erase = go_any && !go_set;
	assign go_f = go_set ? set_dec : erase_dec;
	assign cur_f = op_erase ? erase_dec : set_dec;
	assign cur_mode = dummy_ctrl_pkg::bus_mode_type'(mode_raw);
	assign req_value = sw_wdata_i[dummy_ctrl_pkg::VAL_HI:dummy_ctrl_pkg::VAL_LO];
	assign req_ovr = sw_wdata_i[dummy_ctrl_pkg::OVR_HI:dummy_ctrl_pkg::OVR_LO];
	assign req_mode_raw = sw_wdata_i[dummy_ctrl_pkg::MODE_HI:dummy_ctrl_pkg::MODE_LO];
	assign req_mode = dummy_ctrl_pkg::bus_mode_type'(req_mode_raw);
	assign req_alen = dummy_ctrl_pkg::addr_len_type'(
		sw_wdata_i[dummy_ctrl_pkg::ALEN_HI:dummy_ctrl_pkg::ALEN_LO]);

	// Checks run on the request itself so that no command leaves for a bad word.
	always_comb begin
		go_err = dummy_ctrl_pkg::ERR_NONE;
		if (req_mode_raw > 3'(dummy_ctrl_pkg::MODE_8D8D8D)
				|| req_alen > dummy_ctrl_pkg::ALEN_32) begin
			go_err = dummy_ctrl_pkg::ERR_MODE;
		end else if (!go_f.supported) begin
			go_err = dummy_ctrl_pkg::ERR_UNSUP;
		end else if (go_set && go_f.wr_op == dummy_ctrl_pkg::NO_OPCODE) begin
			go_err = dummy_ctrl_pkg::ERR_NO_WRITE;
		end else if (!go_set && go_f.rd_op == dummy_ctrl_pkg::NO_OPCODE) begin
			go_err = dummy_ctrl_pkg::ERR_NO_READ;
		end else if (go_f.by_addr && go_f.byte1 && req_alen == dummy_ctrl_pkg::ALEN_8) begin
			go_err = dummy_ctrl_pkg::ERR_ADDR;
		end else if (go_set && !field_fits) begin
			go_err = dummy_ctrl_pkg::ERR_FIELD;
		end else if (go_set && !value_fits) begin
			go_err = dummy_ctrl_pkg::ERR_WIDTH;
		end
	end

	// ************************************************************************
	// Software registers
	// ************************************************************************

	// Parameter words are frozen while a sequence runs so the decode stays put.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			set_word <= dummy_ctrl_pkg::WORD_RESET;
			erase_word <= dummy_ctrl_pkg::WORD_RESET;
		end else if (sw_wr_i && state == dummy_ctrl_pkg::ST_IDLE) begin
			if (sw_addr_i == dummy_ctrl_pkg::OFF_SET_WORD) begin
				set_word <= sw_wdata_i;
			end
			if (sw_addr_i == dummy_ctrl_pkg::OFF_ERASE_WORD) begin
				erase_word <= sw_wdata_i;
			end
		end
	end

	// Control fields load on any idle write to the control register.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wait_value <= 5'h00;
			mode_raw <= 3'h0;
			alen <= dummy_ctrl_pkg::ALEN_8;
			dummy_ovr <= 4'h0;
		end else if (sw_wr_i && sw_addr_i == dummy_ctrl_pkg::OFF_CTRL
				&& state == dummy_ctrl_pkg::ST_IDLE) begin
			wait_value <= req_value;
			mode_raw <= req_mode_raw;
			alen <= req_alen;
			dummy_ovr <= req_ovr;
		end
	end

	// Read data stand for exactly one cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sw_rdata_o <= 32'h0000_0000;
		end else begin
			sw_rdata_o <= 32'h0000_0000;
			if (sw_rd_i) begin
				case (sw_addr_i)
					dummy_ctrl_pkg::OFF_CTRL: begin
						sw_rdata_o <= {4'h0, dummy_ovr, 2'h0, alen, 1'b0, mode_raw, 3'h0,
							wait_value, 8'h00};
					end
					dummy_ctrl_pkg::OFF_SET_WORD: begin
						sw_rdata_o <= set_word;
					end
					dummy_ctrl_pkg::OFF_ERASE_WORD: begin
						sw_rdata_o <= erase_word;
					end
					dummy_ctrl_pkg::OFF_STATUS: begin
						sw_rdata_o <= {8'h00, last_rdata, 7'h00, erase_dec.shared,
							(erase_dec.wr_op == dummy_ctrl_pkg::NO_OPCODE),
							erase_bit, unlisted, err, done, busy_o};
					end
					dummy_ctrl_pkg::OFF_DECODE: begin
						sw_rdata_o <= {24'h00_0000, set_dec.supported,
							3'(set_dec.width_code) + 3'h2, pick_dummy(set_dec, cur_mode, dummy_ovr)};
					end
					default: begin
						sw_rdata_o <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// ************************************************************************
	// Sequencer
	// ************************************************************************

	// Set: optional read of the register, then a merged write. Erase: one read.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= dummy_ctrl_pkg::ST_IDLE;
			busy_o <= 1'b0;
		end else begin
			case (state)
				dummy_ctrl_pkg::ST_IDLE: begin
					if (go_any && go_err == dummy_ctrl_pkg::ERR_NONE) begin
						busy_o <= 1'b1;
						if (go_set && go_f.rd_op == dummy_ctrl_pkg::NO_OPCODE) begin
							state <= dummy_ctrl_pkg::ST_WR_ISSUE;
						end else begin
							state <= dummy_ctrl_pkg::ST_RD_ISSUE;
						end
					end
				end
				dummy_ctrl_pkg::ST_RD_ISSUE: begin
					if (cmd_ready_i) begin
						state <= dummy_ctrl_pkg::ST_RD_WAIT;
					end
				end
				dummy_ctrl_pkg::ST_RD_WAIT: begin
					if (rsp_valid_i) begin
						state <= op_erase ? dummy_ctrl_pkg::ST_IDLE : dummy_ctrl_pkg::ST_WR_ISSUE;
						busy_o <= !op_erase;
					end
				end
				dummy_ctrl_pkg::ST_WR_ISSUE: begin
					if (cmd_ready_i) begin
						state <= dummy_ctrl_pkg::ST_WR_WAIT;
					end
				end
				dummy_ctrl_pkg::ST_WR_WAIT: begin
					if (rsp_valid_i) begin
						state <= dummy_ctrl_pkg::ST_IDLE;
						busy_o <= 1'b0;
					end
				end
				default: begin
					state <= dummy_ctrl_pkg::ST_IDLE;
					busy_o <= 1'b0;
				end
			endcase
		end
	end

	// The command is built in one go and held unchanged until the engine takes it.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_o <= '0;
		end else if (go_any && go_err == dummy_ctrl_pkg::ERR_NONE) begin
			cmd_o <= make_cmd(go_set && go_f.rd_op == dummy_ctrl_pkg::NO_OPCODE, go_f,
				req_alen, req_mode, req_ovr, merged);
		end else if (state == dummy_ctrl_pkg::ST_RD_WAIT && rsp_valid_i && !op_erase) begin
			cmd_o <= make_cmd(1'b1, set_dec, alen, cur_mode, dummy_ovr, merged);
		end else if (cmd_o.valid && cmd_ready_i) begin
			cmd_o.valid <= 1'b0;
		end
	end

	// Outcome flags; a new start reloads done, err and unlisted but keeps erase_bit and last_rdata; nothing else competes with the set.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			op_erase <= 1'b0;
			done <= 1'b0;
			err <= dummy_ctrl_pkg::ERR_NONE;
			unlisted <= 1'b0;
			erase_bit <= 1'b0;
			last_rdata <= 8'h00;
		end else if (go_any) begin
			op_erase <= go_erase;
			err <= go_err;
			done <= (go_err != dummy_ctrl_pkg::ERR_NONE);
			unlisted <= !go_f.by_addr && req_mode != dummy_ctrl_pkg::MODE_1S1S1S
				&& !mode_flagged(go_f, req_mode);
		end else if (rsp_valid_i && state == dummy_ctrl_pkg::ST_RD_WAIT) begin
			last_rdata <= rsp_data_i;
			if (op_erase) begin
				erase_bit <= rsp_data_i[erase_dec.lsb_pos];
				done <= 1'b1;
			end
		end else if (rsp_valid_i && state == dummy_ctrl_pkg::ST_WR_WAIT) begin
			done <= 1'b1;
		end
	end

	// ************************************************************************
	// Assertions
	// ************************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	a_support_gate: assert property (go_any && !go_f.supported
		|=> !cmd_o.valid && err != dummy_ctrl_pkg::ERR_NONE && done)
		else $error("command issued for an unsupported word");
	a_wait_width: assert property (go_set && !value_fits
		|=> !cmd_o.valid && state == dummy_ctrl_pkg::ST_IDLE && err != dummy_ctrl_pkg::ERR_NONE)
		else $error("oversized wait value was accepted");
	a_field_contig: assert property (go_set && !field_fits |=> !busy_o)
		else $error("field outside one register was accepted");
	a_direct_no_addr: assert property (cmd_o.valid && !cur_f.by_addr
		|-> !cmd_o.has_addr)
		else $error("plain command carries an address");
	a_addr_last_byte: assert property (cmd_o.valid && cmd_o.has_addr && !cur_f.byte1
		|-> cmd_o.addr == {24'h00_0000, cur_f.local_addr})
		else $error("local address not in last byte");
	a_addr_byte_one: assert property (cmd_o.valid && cmd_o.has_addr && cur_f.byte1
		|-> cmd_o.addr == {16'h0000, cur_f.local_addr, 8'h00}
		&& cmd_o.addr_len != dummy_ctrl_pkg::ALEN_8)
		else $error("byte one address wrong or with 8-bit addressing");
	a_field_aligned: assert property (cmd_o.valid && cmd_o.is_write && !op_erase
		|-> (cmd_o.wdata & merge_mask) == (8'({3'h0, wait_value}) << set_dec.lsb_pos))
		else $error("written field not aligned to its position");
	a_dummy_flagged: assert property (cmd_o.valid && !cmd_o.is_write
		&& !cur_f.by_addr && mode_flagged(cur_f, cmd_o.mode) |-> cmd_o.dummy == cur_f.dummy)
		else $error("flagged mode does not use the shared count");
	a_single_no_dummy: assert property (cmd_o.valid
		&& cmd_o.mode == dummy_ctrl_pkg::MODE_1S1S1S |-> cmd_o.dummy == 4'h0)
		else $error("single line command has dummy cycles");
	a_read_opcode: assert property (cmd_o.valid && !cmd_o.is_write
		|-> cmd_o.opcode == cur_f.rd_op && cmd_o.opcode != dummy_ctrl_pkg::NO_OPCODE)
		else $error("read uses a missing or wrong opcode");
	a_write_opcode: assert property (cmd_o.valid && cmd_o.is_write
		|-> cmd_o.opcode == set_dec.wr_op && cmd_o.opcode != dummy_ctrl_pkg::NO_OPCODE)
		else $error("write uses a missing or wrong opcode");
	a_cmd_holds: assert property (cmd_o.valid && !cmd_ready_i |=> cmd_o.valid && $stable(cmd_o))
		else $error("command changed before it was taken");

	c_direct_set: cover property (go_set && !go_f.by_addr ##[1:30]
		(state == dummy_ctrl_pkg::ST_WR_WAIT && rsp_valid_i));
	c_rmw_set: cover property (state == dummy_ctrl_pkg::ST_RD_WAIT && rsp_valid_i && !op_erase
		##[1:30] (state == dummy_ctrl_pkg::ST_WR_WAIT && rsp_valid_i));
	c_erase_read: cover property (go_erase ##[1:30] (op_erase && done));
	c_refused: cover property (go_any && go_err != dummy_ctrl_pkg::ERR_NONE);

endmodule : dummy_cycle_host

// ### testbench/dev_model.sv
// Device model that answers the host's register commands.
`timescale 1ns/1ps
module dev_model #(parameter logic [7:0] INIT = 8'h5a) (
	// Clock, reset and pacing.
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic slow_i,
	// Command link.
	input dummy_ctrl_pkg::serial_cmd_type cmd_i,
	output logic ready_o,
	output logic rsp_valid_o,
	output logic [7:0] rsp_data_o,
	// Observation.
	output dummy_ctrl_pkg::serial_cmd_type last_o,
	output logic [7:0] reg_o
);
	logic tick;
	logic pend;
	// Slow mode takes a command only every other cycle.
	assign ready_o = !pend && (tick || !slow_i);
	// A read returns the byte, a write replaces it; idle data toggles.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tick <= 1'b0;
			pend <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_data_o <= 8'h00;
			last_o <= '0;
			reg_o <= INIT;
		end else begin
			tick <= !tick;
			pend <= cmd_i.valid && ready_o;
			rsp_valid_o <= pend;
			rsp_data_o <= (pend && !last_o.is_write) ? reg_o : ~rsp_data_o;
			if (cmd_i.valid && ready_o) last_o <= cmd_i;
			if (pend && last_o.is_write) reg_o <= last_o.wdata;
		end
	end
endmodule : dev_model

// ### testbench/dummy_cycle_descriptor_decode_tb_top.sv
// Self-checking bench for the dummy cycle host.
`timescale 1ns/1ps
module dummy_cycle_descriptor_decode_tb_top;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic [7:0] sw_addr_i = 8'h00;
	logic [31:0] sw_wdata_i = 32'h0;
	logic sw_wr_i = 1'b0;
	logic sw_rd_i = 1'b0;
	logic slow_i = 1'b0;
	logic [31:0] sw_rdata_o, rv;
	logic cmd_ready_i, rsp_valid_i, busy_o;
	logic [7:0] rsp_data_i, dev_reg;
	dummy_ctrl_pkg::serial_cmd_type cmd_o, last;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;
	dummy_cycle_host i_dummy_cycle_host (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
		.sw_rdata_o(sw_rdata_o), .cmd_o(cmd_o), .cmd_ready_i(cmd_ready_i),
		.rsp_valid_i(rsp_valid_i), .rsp_data_i(rsp_data_i), .busy_o(busy_o));
	dev_model i_dev_model (.clk_i(core_clk_i), .rstn_i(rstn_i), .slow_i(slow_i),
		.cmd_i(cmd_o), .ready_o(cmd_ready_i), .rsp_valid_o(rsp_valid_i),
		.rsp_data_o(rsp_data_i), .last_o(last), .reg_o(dev_reg));
	initial forever #12.5 core_clk_i = ~core_clk_i;
	// The tests need about a hundred cycles, so this ceiling only cuts a hang.
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles > 3000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		sw_addr_i <= a;
		sw_wdata_i <= d;
		sw_wr_i <= 1'b1;
		@(posedge core_clk_i);
		sw_wr_i <= 1'b0;
	endtask : sw_write
	task automatic sw_read(input logic [7:0] a);
		@(posedge core_clk_i);
		sw_addr_i <= a;
		sw_rd_i <= 1'b1;
		@(posedge core_clk_i);
		sw_rd_i <= 1'b0;
		#1 rv = sw_rdata_o;
	endtask : sw_read
	// Loads a word, starts the job, waits for idle and reads status.
	task automatic run(input logic [7:0] off, input logic [31:0] w, input logic [31:0] c);
		sw_write(off, w);
		sw_write(8'h00, c);
		#1;
		for (int n = 0; n < 200 && busy_o !== 1'b0; n++) @(posedge core_clk_i) #1;
		// A job that never ends counts against the run even if later values look right.
		if (busy_o !== 1'b0) mismatches++;
		sw_read(8'h0c);
	endtask : run
	// Starts a job that must be refused and compares the error and done bits.
	task automatic refuse(input logic [7:0] off, input logic [31:0] w, input logic [31:0] c,
			input logic [4:0] e);
		run(off, w, c);
		chk(rv[4:0], e);
	endtask : refuse
	task automatic t_refuse;
		sw_read(8'h14);
		chk(rv, 32'h0);
		run(8'h04, 32'h7fff_ffff, 32'h0000_0101);
		chk(rv[4:0], 5'h06);
		chk(last.valid, 1'b0);
		sw_read(8'h10);
		chk(rv, 32'h20);
		run(8'h04, 32'h9812_0102, 32'h0000_0101);
		chk(rv[4:0], 5'h1a);
		refuse(8'h04, 32'he400_0102, 32'h0000_0101, 5'h16);
		refuse(8'h04, 32'h8000_0102, 32'h0000_0401, 5'h12);
		refuse(8'h04, 32'h8000_0100, 32'h0000_0101, 5'h0a);
		refuse(8'h08, 32'h8000_0002, 32'h0000_0002, 5'h0e);
		refuse(8'h04, 32'h8000_0102, 32'h0005_0101, 5'h1e);
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_rmw;
		slow_i <= 1'b1;
		run(8'h04, 32'hba3c_8581, 32'h0010_0501);
		chk(dev_reg, 8'h56);
		chk(last.addr, 32'h3c00);
		chk(last.opcode, 8'h81);
		chk({rv[23:16], rv[4:0]}, {8'h5a, 5'h02});
		slow_i <= 1'b0;
		$display("test rmw done");
	endtask : t_rmw
	task automatic t_plain;
		run(8'h04, 32'he049_0071, 32'h0703_1f01);
		chk(rv[5:0], 6'h02);
		chk(dev_reg, 8'h1f);
		chk({last.has_addr, last.dummy, last.wdata}, 13'h1f);
		sw_read(8'h10);
		chk(rv, 32'hd9);
		sw_write(8'h00, 32'h0700_0000);
		sw_read(8'h10);
		chk(rv, 32'hd0);
		sw_write(8'h00, 32'h0701_0000);
		sw_read(8'h10);
		chk(rv, 32'hd7);
		$display("test plain done");
	endtask : t_plain
	task automatic t_erase;
		run(8'h08, 32'hb320_0500, 32'h0020_0002);
		chk(rv & 32'h00ff_01df, 32'h001f_01c2);
		chk({last.has_addr, last.addr}, {1'b1, 32'h20});
		$display("test erase done");
	endtask : t_erase
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (8) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		t_refuse();
		t_rmw();
		t_plain();
		t_erase();
		end_sim();
	end
endmodule : dummy_cycle_descriptor_decode_tb_top
